// [design/rcsi_consts.svh]
// Constants for the reclose status indicator block.
// Assumes a 125 MHz clock and a 32-bit classic Wishbone slave port.
`ifndef RCSI_CONSTS_SVH
`define RCSI_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RCSI_OFS_CTRL      8'h00
`define RCSI_OFS_TIME_A    8'h04
`define RCSI_OFS_TIME_B    8'h08
`define RCSI_OFS_STATUS    8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCSI_CTRL_EN       0
`define RCSI_CTRL_USE      1
`define RCSI_CTRL_SHOT_LSB 4
`define RCSI_CTRL_SHOT_MSB 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCSI_RST_CTRL      32'h0000_0010
`define RCSI_RST_ARC_MS    16'h0064
`define RCSI_RST_DEAD_MS   16'h01f4
`define RCSI_RST_RECL_MS   16'h2710
`define RCSI_RST_LOCK_MS   16'h1388

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCSI_CLK_NS        8
`define RCSI_TICK_NS       1000000
`define RCSI_TICK_CYC      (`RCSI_TICK_NS / `RCSI_CLK_NS)
`define RCSI_PRE_W         17
`define RCSI_SHOTS         5

`endif

// [design/rcsi_indicators.sv]
// Reclosing sequencer with status indicator outputs and Wishbone registers.
// Assumes request and control pins come from other logic domains and the
// object control function reports breaker position on two pins.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "rcsi_consts.svh"

// Contract
// - Outputs are status only; no breaker open or close commands driven here.
// - Enabled indicator is high whenever the function is enabled.
// - Disabled indicator high when on/off input used and that input inactive.
// - In-progress and dead-time indicators high while breaker open, timing reclose.
// - Five request-active indicators, each high for a shot started by that request.
// - Five shot-running indicators, each high while that shot number executes.
// - Running indicator high whenever state is running.
// - Sequence-done high after last reclose, awaiting final trip or reclaim expiry.
// - Final-trip indicator high once the final trip has been executed.
// - Arcing-time indicator high while the arcing interval is counted.
// - Reclaim-time indicator high while the reclaim interval is counted.
// - Ready indicator high when a sequence can start on a fault.
// - Post-success lockout high when fault arrives before lockout interval ends.
// - During post-success lockout no new sequence starts; function goes locked.
// - Inhibit indicator high whenever state is inhibit.
// - Locked indicator high whenever state is locked.
// - Request one has highest priority, falling down to request five.
// - Critical request moves an enabled function immediately to locked.
// - Manual unlock input releases the function from locked.
// - With on/off usage off, function counts as always in use.
module rcsi_indicators
    import rcsi_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RCSI_TICK_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Relay inputs, asynchronous
    input  wire logic [4:0]  request_in_i,
    input  wire logic        onoff_input_i,
    input  wire logic        critical_request_in_i,
    input  wire logic        manual_unlock_in_i,
    input  wire logic        breaker_open_i,
    input  wire logic        breaker_closed_i,
    // Indicators, status only
    output logic             reclose_enabled_ind_o,
    output logic             reclose_disabled_ind_o,
    output logic             in_progress_ind_o,
    output logic             dead_time_ind_o,
    output logic             running_ind_o,
    output logic             sequence_done_ind_o,
    output logic             final_trip_ind_o,
    output logic             arcing_time_ind_o,
    output logic             reclaim_time_ind_o,
    output logic             ready_ind_o,
    output logic             post_success_lockout_ind_o,
    output logic             inhibit_ind_o,
    output logic             locked_ind_o,
    output logic      [4:0]  request_active_ind_o,
    output logic      [4:0]  shot_running_ind_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [4:0] prio_pick(input logic [4:0] r);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 4; i >= 0; i--) begin
            if (r[i]) begin
                p = 5'h00;
                p[i] = 1'b1;
            end
        end
        return p;
    endfunction : prio_pick

    function automatic logic [4:0] shot_dec(input logic [2:0] n);
        logic [4:0] v;
        v = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (n == 3'(i + 1)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction : shot_dec

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    rcsi_regs_s q;
    rcsi_regs_s d;
    logic [9:0] pins;
    logic [4:0] req_s;
    logic       onoff_s;
    logic       crit_s;
    logic       man_s;
    logic       bopen_s;
    logic       bclos_s;
    logic       fault;
    logic       enabled;
    logic       tick;
    logic       done;
    logic [2:0] last;
    logic [31:0] ctrl_rd;
    logic [31:0] time_a;
    logic [31:0] time_b;
    logic [31:0] status;
    logic       is_run;

    assign pins = {breaker_closed_i, breaker_open_i, manual_unlock_in_i,
                   critical_request_in_i, onoff_input_i, request_in_i};
    assign req_s   = q.sy2[4:0];
    assign onoff_s = q.sy2[5];
    assign crit_s  = q.sy2[6];
    assign man_s   = q.sy2[7];
    assign bopen_s = q.sy2[8];
    assign bclos_s = q.sy2[9];
    assign fault   = |req_s;
    assign enabled = q.mode_en & (~q.use_onoff | onoff_s);
    assign tick    = (q.pre == 17'(TICK_CYCLES - 1));
    assign done    = (q.tmr == 16'h0000);
    // Out-of-range shot settings fall back to a single shot
    assign last    = (q.last_shot == 3'h0 || q.last_shot > 3'h5) ? 3'h1 : q.last_shot;
    assign ctrl_rd = {25'h0000000, q.last_shot, 2'h0, q.use_onoff, q.mode_en};
    assign time_a  = {q.dead_ms, q.arc_ms};
    assign time_b  = {q.lock_ms, q.recl_ms};
    assign status  = {3'h0, q.st, q.i_shot, q.i_req, q.i_en, q.i_dis, q.i_prog,
                      q.i_run, q.i_seq, q.ft, q.i_arc, q.i_recl, q.i_rdy, q.psl,
                      q.i_inh, q.i_lck};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        is_run = 1'b0;
        d.ack = 1'b0;
        d.sy1 = pins;
        d.sy2 = q.sy1;
        d.pre = tick ? 17'h00000 : q.pre + 17'h00001;
        if (tick && !done) begin
            d.tmr = q.tmr - 16'h0001;
        end
        // Register access, one wait state
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            d.ack = 1'b1;
            case (wb_adr_i)
                `RCSI_OFS_CTRL: d.dat = ctrl_rd;
                `RCSI_OFS_TIME_A: d.dat = time_a;
                `RCSI_OFS_TIME_B: d.dat = time_b;
                `RCSI_OFS_STATUS: d.dat = status;
                default: d.dat = 32'h0000_0000;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    `RCSI_OFS_CTRL: begin
                        if (wb_sel_i[0]) begin
                            d.mode_en   = wb_dat_i[`RCSI_CTRL_EN];
                            d.use_onoff = wb_dat_i[`RCSI_CTRL_USE];
                            d.last_shot = wb_dat_i[`RCSI_CTRL_SHOT_MSB:`RCSI_CTRL_SHOT_LSB];
                        end
                    end
                    `RCSI_OFS_TIME_A: {d.dead_ms, d.arc_ms} = wmerge(time_a, wb_dat_i, wb_sel_i);
                    `RCSI_OFS_TIME_B: {d.lock_ms, d.recl_ms} = wmerge(time_b, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
        // ----------------------------------------
        // Reclosing sequence
        // ----------------------------------------
        case (q.st)
            ST_INHIBIT: begin
                d.st = ST_READY;
            end
            ST_READY: begin
                if (fault) begin
                    d.req = prio_pick(req_s);
                    d.shot = 3'h1;
                    d.tmr = q.arc_ms;
                    d.st = ST_ARCING;
                end
            end
            ST_ARCING: begin
                // Fault cleared before a trip: nothing to reclose
                if (!fault) begin
                    d.st = ST_READY;
                end else if (done && bopen_s) begin
                    d.tmr = q.dead_ms;
                    d.st = ST_DEAD;
                end
            end
            ST_DEAD: begin
                if (done && bclos_s) begin
                    d.tmr = q.recl_ms;
                    d.st = ST_RECLAIM;
                end
            end
            ST_RECLAIM: begin
                if (fault && q.shot < last) begin
                    d.req = prio_pick(req_s);
                    d.shot = q.shot + 3'h1;
                    d.tmr = q.arc_ms;
                    d.st = ST_ARCING;
                end else if (fault) begin
                    d.ft = 1'b1;
                    d.st = ST_LOCKED;
                end else if (done) begin
                    d.tmr = q.lock_ms;
                    d.st = ST_LOCKOUT;
                end
            end
            ST_LOCKOUT: begin
                if (fault) begin
                    d.psl = 1'b1;
                    d.st = ST_LOCKED;
                end else if (done) begin
                    d.st = ST_READY;
                end
            end
            ST_LOCKED: begin
                if (man_s) begin
                    d.ft = 1'b0;
                    d.psl = 1'b0;
                    d.st = ST_READY;
                end
            end
            default: d.st = ST_INHIBIT;
        endcase
        if (crit_s && enabled) begin
            d.st = ST_LOCKED;
        end
        // Locked survives a disable so an unlock is still required
        if (!enabled && d.st != ST_LOCKED) begin
            d.st = ST_INHIBIT;
        end
        is_run = (d.st == ST_ARCING) || (d.st == ST_DEAD) || (d.st == ST_RECLAIM);
        if (!is_run) begin
            d.req = 5'h00;
            d.shot = 3'h0;
        end
        // ----------------------------------------
        // Indicators, registered; state indicators from next state, enabled and disabled from current inputs
        // ----------------------------------------
        d.i_en   = enabled;
        d.i_dis  = q.use_onoff & ~onoff_s;
        d.i_prog = (d.st == ST_DEAD);
        d.i_run  = is_run;
        d.i_seq  = (d.st == ST_RECLAIM) && (d.shot == last);
        d.i_arc  = (d.st == ST_ARCING);
        d.i_recl = (d.st == ST_RECLAIM);
        d.i_rdy  = (d.st == ST_READY);
        d.i_inh  = (d.st == ST_INHIBIT);
        d.i_lck  = (d.st == ST_LOCKED);
        d.i_req  = d.req;
        d.i_shot = shot_dec(d.shot);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_INHIBIT;
            q.mode_en <= 1'((`RCSI_RST_CTRL >> `RCSI_CTRL_EN) & 32'h1);
            q.use_onoff <= 1'((`RCSI_RST_CTRL >> `RCSI_CTRL_USE) & 32'h1);
            q.last_shot <= 3'((`RCSI_RST_CTRL >> `RCSI_CTRL_SHOT_LSB) & 32'h7);
            q.arc_ms <= `RCSI_RST_ARC_MS;
            q.dead_ms <= `RCSI_RST_DEAD_MS;
            q.recl_ms <= `RCSI_RST_RECL_MS;
            q.lock_ms <= `RCSI_RST_LOCK_MS;
            q.i_inh <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs, status only, no breaker commands
    // ----------------------------------------
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign reclose_enabled_ind_o = q.i_en;
    assign reclose_disabled_ind_o = q.i_dis;
    assign in_progress_ind_o = q.i_prog;
    assign dead_time_ind_o = q.i_prog;
    assign running_ind_o = q.i_run;
    assign sequence_done_ind_o = q.i_seq;
    assign final_trip_ind_o = q.ft;
    assign arcing_time_ind_o = q.i_arc;
    assign reclaim_time_ind_o = q.i_recl;
    assign ready_ind_o = q.i_rdy;
    assign post_success_lockout_ind_o = q.psl;
    assign inhibit_ind_o = q.i_inh;
    assign locked_ind_o = q.i_lck;
    assign request_active_ind_o = q.i_req;
    assign shot_running_ind_o = q.i_shot;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ENABLED: assert property (
        ##1 reclose_enabled_ind_o == $past(enabled))
        else $error("enabled indicator wrong");
    AST_DISABLED: assert property (
        q.use_onoff && !onoff_s && $stable(q.use_onoff) |=> reclose_disabled_ind_o)
        else $error("disabled indicator missing");
    AST_DEAD: assert property (
        dead_time_ind_o |-> in_progress_ind_o && running_ind_o && shot_running_ind_o != 5'h00)
        else $error("dead time without progress");
    AST_ONEHOT: assert property (
        $onehot0(shot_running_ind_o) && $onehot0(request_active_ind_o))
        else $error("more than one shot or request active");
    AST_RUN: assert property (
        running_ind_o |-> request_active_ind_o != 5'h00 && !ready_ind_o && !locked_ind_o)
        else $error("running without a request");
    AST_PRIO: assert property (
        q.st == ST_READY && fault && enabled && !crit_s |=>
            request_active_ind_o == prio_pick($past(req_s)) && shot_running_ind_o == 5'h01)
        else $error("wrong request chosen");
    AST_CRIT: assert property (
        crit_s && enabled |=> locked_ind_o && !running_ind_o)
        else $error("critical request did not lock");
    AST_UNLOCK: assert property (
        q.st == ST_LOCKED && man_s && enabled && !crit_s |=> ready_ind_o ##0 !final_trip_ind_o)
        else $error("manual unlock ignored");
    AST_PSL: assert property (
        q.st == ST_LOCKOUT && fault && enabled && !crit_s |=>
            post_success_lockout_ind_o && locked_ind_o ##1 !arcing_time_ind_o)
        else $error("lockout fault started a sequence");
    AST_SEQ: assert property (
        sequence_done_ind_o |-> reclaim_time_ind_o && shot_running_ind_o == shot_dec(last))
        else $error("sequence done outside last reclaim");
    AST_ACK: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    COV_FINAL: cover property (sequence_done_ind_o ##1 final_trip_ind_o);
    COV_PSL: cover property ($rose(post_success_lockout_ind_o));
    COV_SHOT2: cover property (shot_running_ind_o == 5'h02 && dead_time_ind_o);
    COV_UNLOCK: cover property (locked_ind_o ##1 ready_ind_o);

endmodule : rcsi_indicators

// [design/rcsi_pkg.sv]
// Types for the reclose status indicator block.
// Assumes the constants header is compiled alongside.
package rcsi_pkg;

    // ----------------------------------------
    // Reclosing states
    // ----------------------------------------
    typedef enum logic [6:0] {
        ST_INHIBIT = 7'h01,
        ST_READY   = 7'h02,
        ST_ARCING  = 7'h04,
        ST_DEAD    = 7'h08,
        ST_RECLAIM = 7'h10,
        ST_LOCKOUT = 7'h20,
        ST_LOCKED  = 7'h40
    } rcsi_state_e;

    // ----------------------------------------
    // Whole module state
    // ----------------------------------------
    typedef struct packed {
        rcsi_state_e st;
        logic [9:0]  sy1;
        logic [9:0]  sy2;
        logic        mode_en;
        logic        use_onoff;
        logic [2:0]  last_shot;
        logic [15:0] arc_ms;
        logic [15:0] dead_ms;
        logic [15:0] recl_ms;
        logic [15:0] lock_ms;
        logic [16:0] pre;
        logic [15:0] tmr;
        logic [4:0]  req;
        logic [2:0]  shot;
        logic        ft;
        logic        psl;
        logic        ack;
        logic [31:0] dat;
        logic        i_en;
        logic        i_dis;
        logic        i_prog;
        logic        i_run;
        logic        i_seq;
        logic        i_arc;
        logic        i_recl;
        logic        i_rdy;
        logic        i_inh;
        logic        i_lck;
        logic [4:0]  i_req;
        logic [4:0]  i_shot;
    } rcsi_regs_s;

endpackage : rcsi_pkg

// [sim/rcsi_breaker_model.sv]
// Behavioural breaker seen through the object control function.
// Assumes it only watches the status indicators of the block.
`timescale 1ns/10ps

module rcsi_breaker_model #(
    parameter int OPEN_DLY  = 3,
    parameter int CLOSE_DLY = 5
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic arcing_i,
    input  wire logic dead_i,
    input  wire logic ready_i,
    output logic      breaker_open_o,
    output logic      breaker_closed_o
);
    int cnt;

    // ----------------------------------------
    // Trip during arcing, close on its own timing
    // ----------------------------------------
    // The block never commands the breaker; it is moved here only
    always @(posedge clk_i) begin
        if (rst_i) begin
            breaker_open_o <= 1'b0;
            cnt            <= 0;
        end else if (!breaker_open_o && arcing_i) begin
            cnt <= cnt + 1;
            if (cnt >= OPEN_DLY) begin
                breaker_open_o <= 1'b1;
                cnt            <= 0;
            end
        end else if (breaker_open_o && (dead_i || ready_i)) begin
            cnt <= cnt + 1;
            if (cnt >= CLOSE_DLY) begin
                breaker_open_o <= 1'b0;
                cnt            <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end

    assign breaker_closed_o = !breaker_open_o;
endmodule : rcsi_breaker_model

// [sim/rcsi_indicators_tb_top.sv]
// Self-checking bench for the reclose status indicator block.
// Assumes the breaker model and a 4-cycle millisecond tick.
`timescale 1ns/10ps
`include "rcsi_consts.svh"

module rcsi_indicators_tb_top;
    import rcsi_pkg::*;
    localparam int L_LCK = 0, L_PSL = 2, L_RDY = 3, L_RECL = 4, L_ARC = 5;
    localparam int L_FT = 6, L_SEQ = 7, L_RUN = 8, L_PROG = 9, L_DIS = 10;
    localparam int L_EN = 11, L_DEAD = 12, L_INH = 1;

    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, onoff, crit, unlock;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel, sel_n;
    logic [31:0] wb_dat, wb_dat_o, lfsr;
    logic        wb_ack_o, brk_open, brk_closed;
    logic [4:0]  req, req_act, shot, v;
    logic        en, dis, prog, dead, run, seq, ft, arc, recl, rdy, psl, inh, lck;
    logic [12:0] ind;
    logic [31:0] exp_q[$];
    int          fail_count, n_compared;

    assign ind = {dead, en, dis, prog, run, seq, ft, arc, recl, rdy, psl, inh, lck};

    rcsi_indicators #(.TICK_CYCLES(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .request_in_i(req),
        .onoff_input_i(onoff), .critical_request_in_i(crit),
        .manual_unlock_in_i(unlock), .breaker_open_i(brk_open),
        .breaker_closed_i(brk_closed), .reclose_enabled_ind_o(en),
        .reclose_disabled_ind_o(dis), .in_progress_ind_o(prog), .dead_time_ind_o(dead),
        .running_ind_o(run), .sequence_done_ind_o(seq), .final_trip_ind_o(ft),
        .arcing_time_ind_o(arc), .reclaim_time_ind_o(recl), .ready_ind_o(rdy),
        .post_success_lockout_ind_o(psl), .inhibit_ind_o(inh), .locked_ind_o(lck),
        .request_active_ind_o(req_act), .shot_running_ind_o(shot));

    rcsi_breaker_model #(.OPEN_DLY(3), .CLOSE_DLY(5)) i_brk (
        .clk_i(clk_i), .rst_i(rst_i), .arcing_i(arc), .dead_i(dead), .ready_i(rdy),
        .breaker_open_o(brk_open), .breaker_closed_o(brk_closed));

    // ----------------------------------------
    // Clock, checks and closing
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Read data is compared against the oldest note when ack appears
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
            check(wb_dat_o, exp_q.pop_front(), "read data");
        end
        if (rst_i === 1'b0) begin
            check({$onehot0(req_act), $onehot0(shot)}, 2'b11, "one-hot");
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= sel_n;
        if (!we) exp_q.push_back(d);
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_cycle

    // Polling is bounded so a stuck state shows as a mismatch, not a hang
    task automatic wait_ind(input int b, input logic val);
        int n;
        n = 0;
        while (ind[b] !== val && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        #1;
    endtask : wait_ind

    task automatic drive(input logic [4:0] r, input logic c, input logic u);
        @(posedge clk_i);
        req    <= r;
        crit   <= c;
        unlock <= u;
    endtask : drive

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {wb_cyc, wb_stb, wb_we, crit, unlock, onoff} = '0;
        {wb_adr, wb_sel, wb_dat, req} = '0;
        sel_n = 4'hf;
        fail_count = 0;
        n_compared = 0;
        lfsr = 32'h783c;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check(ind, 13'h0002, "reset indicators");
        wb_cycle(1'b0, `RCSI_OFS_CTRL, `RCSI_RST_CTRL);
        wb_cycle(1'b0, `RCSI_OFS_TIME_A, {`RCSI_RST_DEAD_MS, `RCSI_RST_ARC_MS});
        wb_cycle(1'b0, `RCSI_OFS_TIME_B, {`RCSI_RST_LOCK_MS, `RCSI_RST_RECL_MS});
        wb_cycle(1'b0, `RCSI_OFS_STATUS, 32'h0040_0002);
        wb_cycle(1'b1, 8'h10, 32'hffff_ffff);
        wb_cycle(1'b0, 8'h10, 32'h0);
        wb_cycle(1'b1, `RCSI_OFS_TIME_A, 32'h0003_000a);
        wb_cycle(1'b1, `RCSI_OFS_TIME_B, 32'h0006_0006);
        wb_cycle(1'b0, `RCSI_OFS_TIME_A, 32'h0003_000a);
        // On/off input in use but inactive
        wb_cycle(1'b1, `RCSI_OFS_CTRL, 32'h0000_0023);
        repeat (4) @(posedge clk_i);
        #1;
        check({dis, en, inh}, 3'b101, "off input");
        @(posedge clk_i) onoff <= 1'b1;
        wait_ind(L_RDY, 1'b1);
        check({dis, en, rdy, inh}, 4'b0110, "on input");
        wb_cycle(1'b1, `RCSI_OFS_CTRL, 32'h0000_0021);
        onoff <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check({dis, en, rdy}, 3'b011, "input unused");
        // Byte lanes: CTRL needs lane 0, timer fields honour each lane
        sel_n = 4'he;
        wb_cycle(1'b1, `RCSI_OFS_CTRL, 32'h0000_0000);
        sel_n = 4'h3;
        wb_cycle(1'b1, `RCSI_OFS_TIME_A, 32'hffff_0009);
        sel_n = 4'hf;
        wb_cycle(1'b0, `RCSI_OFS_CTRL, 32'h0000_0021);
        wb_cycle(1'b0, `RCSI_OFS_TIME_A, 32'h0003_0009);
        // Random request sets, abandoned before the arcing time ends
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            v = (lfsr[4:0] == 5'h0) ? 5'h01 : lfsr[4:0];
            drive(v, 1'b0, 1'b0);
            wait_ind(L_RUN, 1'b1);
            check({req_act, shot, arc}, {v & (~v + 5'h1), 5'h01, 1'b1}, "pick");
            drive(5'h0, 1'b0, 1'b0);
            wait_ind(L_RDY, 1'b1);
        end
        // Two-shot sequence ending in final trip
        drive(5'h04, 1'b0, 1'b0);
        wait_ind(L_DEAD, 1'b1);
        check({prog, dead, req_act}, {2'b11, 5'h04}, "dead time");
        drive(5'h0, 1'b0, 1'b0);
        wait_ind(L_RECL, 1'b1);
        check({recl, seq, prog}, 3'b100, "reclaim shot 1");
        drive(5'h18, 1'b0, 1'b0);
        wait_ind(L_ARC, 1'b1);
        check({req_act, shot}, {5'h08, 5'h02}, "second shot");
        wait_ind(L_DEAD, 1'b1);
        drive(5'h0, 1'b0, 1'b0);
        wait_ind(L_SEQ, 1'b1);
        check({seq, recl}, 2'b11, "sequence done");
        drive(5'h01, 1'b0, 1'b0);
        wait_ind(L_LCK, 1'b1);
        check({ft, lck, rdy}, 3'b110, "final trip");
        drive(5'h0, 1'b0, 1'b1);
        wait_ind(L_RDY, 1'b1);
        check({ft, lck}, 2'b00, "unlock");
        // Success, then a fault during the lockout interval
        drive(5'h01, 1'b0, 1'b0);
        wait_ind(L_DEAD, 1'b1);
        drive(5'h0, 1'b0, 1'b0);
        wait_ind(L_RECL, 1'b1);
        wait_ind(L_RECL, 1'b0);
        check({rdy, lck, run}, 3'b000, "lockout interval");
        drive(5'h02, 1'b0, 1'b0);
        wait_ind(L_LCK, 1'b1);
        check({psl, lck, arc, rdy}, 4'b1100, "post-success lockout");
        drive(5'h0, 1'b0, 1'b1);
        wait_ind(L_RDY, 1'b1);
        check(psl, 1'b0, "unlock clears");
        // Critical request from ready
        drive(5'h0, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        check({lck, rdy}, 2'b10, "critical");
        drive(5'h0, 1'b0, 1'b1);
        wait_ind(L_RDY, 1'b1);
        drive(5'h0, 1'b0, 1'b0);
        wb_cycle(1'b1, `RCSI_OFS_CTRL, 32'h0000_0020);
        wait_ind(L_INH, 1'b1);
        check({inh, en, rdy}, 3'b100, "disabled");
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule : rcsi_indicators_tb_top
